// ==== hdl/token_host.sv ====
/*
 * Host-side controller for one port of the token latches.
 * A claim writes zero, waits the release gap, and polls until a zero
 * is read back; a release writes one. Drives the port pins directly.
 * Assumes the device answers within one strobe width and that data
 * inputs are synchronous to sys_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module token_host #(
	parameter int DATA_W = token_host_pkg::DATA_W,
	parameter int ADDR_W = token_host_pkg::ADDR_W
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_b_i,
	// User side
	input  wire logic                 claim_i,
	input  wire logic                 release_i,
	input  wire logic                 cancel_i,
	input  wire logic [2:0]           token_idx_i,
	output logic                      ready_o,
	output logic                      done_o,
	output logic                      owned_o,
	output logic [7:0]                held_o,
	// Device port pins
	output logic                      token_select_n_o,
	output logic                      mem_select_n_o,
	output logic                      out_en_n_o,
	output logic                      write_n_o,
	output logic [ADDR_W-1:0]         addr_o,
	input  wire logic [DATA_W-1:0]    data_i,
	output logic [DATA_W-1:0]         data_o,
	output logic                      data_oe_n_o
);
	localparam int CNT_W = token_host_pkg::CNT_W;

	// Phase lengths in clock cycles, rounded up from the pin timing
	localparam logic [CNT_W-1:0] STROBE_LD = CNT_W'(token_host_pkg::STROBE_CYC);
	localparam logic [CNT_W-1:0] GAP_LD    = CNT_W'(token_host_pkg::RELEASE_GAP_CYC);

	// One-hot mask of a token index; sets and clears the held bits
	function automatic logic [7:0] idx_mask(input logic [2:0] idx);
		idx_mask = 8'h01 << idx;
	endfunction : idx_mask

	// State and request bookkeeping
	token_host_pkg::host_state_t state_ff;
	token_host_pkg::host_state_t nxt_state;
	logic [2:0]                  idx_ff;
	logic [2:0]                  nxt_idx;
	logic                        wr_one_ff;
	logic                        nxt_wr_one;
	logic                        cancel_ff;
	logic                        nxt_cancel;
	logic                        owned_ff;
	logic                        nxt_owned;
	logic [7:0]                  held_ff;
	logic [7:0]                  nxt_held;

	// Registered pin drivers
	logic                        sel_n_ff;
	logic                        nxt_sel_n;
	logic                        write_n_ff;
	logic                        nxt_write_n;
	logic                        oe_n_ff;
	logic                        nxt_oe_n;
	logic                        drive_n_ff;
	logic                        nxt_drive_n;
	logic [DATA_W-1:0]           data_ff;
	logic [DATA_W-1:0]           nxt_data;
	logic [ADDR_W-1:0]           addr_ff;
	logic [ADDR_W-1:0]           nxt_addr;

	// Decode of the current state
	logic                        in_idle;
	logic                        in_write;
	logic                        in_gap;
	logic                        in_read;
	logic                        in_poll;
	logic                        in_done;

	// Decode of the next state
	logic                        to_write;
	logic                        to_read;
	logic                        state_change;

	// Phase timer
	logic                        timer_load;
	logic [CNT_W-1:0]            timer_count;
	logic                        timer_expired;

	// Events
	logic                        start_claim;
	logic                        start_release;
	logic                        write_end;
	logic                        gap_end;
	logic                        read_end;
	logic                        poll_end;
	logic                        read_zero;
	logic                        win;
	logic                        one_written;
	logic [7:0]                  cur_mask;

	assign in_idle  = (state_ff == token_host_pkg::ST_IDLE);
	assign in_write = (state_ff == token_host_pkg::ST_WRITE);
	assign in_gap   = (state_ff == token_host_pkg::ST_GAP);
	assign in_read  = (state_ff == token_host_pkg::ST_READ);
	assign in_poll  = (state_ff == token_host_pkg::ST_POLL);
	assign in_done  = (state_ff == token_host_pkg::ST_DONE);

	assign to_write     = (nxt_state == token_host_pkg::ST_WRITE);
	assign to_read      = (nxt_state == token_host_pkg::ST_READ);
	assign state_change = (nxt_state != state_ff);

	// A claim wins over a release offered in the same cycle
	assign start_claim   = in_idle && claim_i;
	assign start_release = in_idle && !claim_i && release_i;

	assign write_end = in_write && timer_expired;
	assign gap_end   = in_gap && timer_expired;
	assign read_end  = in_read && timer_expired;
	assign poll_end  = in_poll && timer_expired;

	// Every data line carries the token value, so all-zero means ours
	assign read_zero   = (data_i == '0);                      // RQ4
	assign win         = read_end && read_zero;               // RQ4
	assign one_written = write_end && wr_one_ff;              // RQ5
	assign cur_mask    = idx_mask(idx_ff);

	// Every phase starts with a fresh load; strobes and gaps differ in length
	assign timer_load  = state_change;
	assign timer_count = (to_write || to_read) ? STROBE_LD : GAP_LD;

	cycle_timer #(
		.W         (CNT_W)
	) i_phase_timer (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.load_i    (timer_load),
		.count_i   (timer_count),
		.expired_o (timer_expired)
	);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			token_host_pkg::ST_IDLE: begin
				if (start_claim || start_release) begin
					nxt_state = token_host_pkg::ST_WRITE;
				end
			end
			token_host_pkg::ST_WRITE: begin
				// A zero is followed by the readback, a one ends the job
				if (write_end) begin
					nxt_state = wr_one_ff ? token_host_pkg::ST_DONE
						: token_host_pkg::ST_GAP;          // RQ2
				end
			end
			token_host_pkg::ST_GAP: begin
				// Select stays high for the release gap before the read
				if (gap_end) begin
					nxt_state = token_host_pkg::ST_READ;   // RQ3
				end
			end
			token_host_pkg::ST_READ: begin
				if (read_end) begin
					nxt_state = read_zero ? token_host_pkg::ST_DONE
						: token_host_pkg::ST_POLL;         // RQ4
				end
			end
			token_host_pkg::ST_POLL: begin
				// A withdraw goes out as a one; otherwise keep polling
				if (poll_end) begin
					nxt_state = cancel_ff ? token_host_pkg::ST_WRITE
						: token_host_pkg::ST_READ;         // RQ4 RQ5
				end
			end
			token_host_pkg::ST_DONE: begin
				nxt_state = token_host_pkg::ST_IDLE;
			end
			default: begin
				// Illegal one-hot code: fall back to idle
				nxt_state = token_host_pkg::ST_IDLE;
			end
		endcase
	end

	always_comb begin
		nxt_idx    = idx_ff;
		nxt_wr_one = wr_one_ff;
		if (start_claim || start_release) begin
			nxt_idx    = token_idx_i;
			nxt_wr_one = start_release;                   // RQ2 RQ5
		end else if (poll_end && cancel_ff) begin
			nxt_wr_one = 1'b1;                            // RQ5
		end
	end

	// A cancel is kept until the job ends; it only acts between polls
	assign nxt_cancel = in_done ? 1'b0 : (cancel_ff || (cancel_i && !in_idle));

	always_comb begin
		nxt_owned = owned_ff;
		nxt_held  = held_ff;
		if (win) begin
			nxt_owned = 1'b1;
			nxt_held  = held_ff | cur_mask;
		end else if (one_written) begin
			nxt_owned = 1'b0;
			nxt_held  = held_ff & ~cur_mask;
		end
	end

	// Pins follow the next state so they change together on one edge
	assign nxt_sel_n   = !(to_write || to_read);            // RQ6 RQ17
	assign nxt_write_n = !to_write;                         // RQ8
	assign nxt_oe_n    = !to_read;                          // RQ8 RQ17
	assign nxt_drive_n = !to_write;
	assign nxt_data    = DATA_W'(nxt_wr_one);
	// Upper address lines are held low; only the token index matters
	assign nxt_addr    = ADDR_W'(nxt_idx);

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= token_host_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idx_ff    <= '0;
			wr_one_ff <= 1'b0;
			cancel_ff <= 1'b0;
		end else begin
			idx_ff    <= nxt_idx;
			wr_one_ff <= nxt_wr_one;
			cancel_ff <= nxt_cancel;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			owned_ff <= 1'b0;
			held_ff  <= '0;
		end else begin
			owned_ff <= nxt_owned;
			held_ff  <= nxt_held;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sel_n_ff   <= 1'b1;
			write_n_ff <= 1'b1;
			oe_n_ff    <= 1'b1;
			drive_n_ff <= 1'b1;
		end else begin
			sel_n_ff   <= nxt_sel_n;
			write_n_ff <= nxt_write_n;
			oe_n_ff    <= nxt_oe_n;
			drive_n_ff <= nxt_drive_n;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			data_ff <= '0;
			addr_ff <= '0;
		end else begin
			data_ff <= nxt_data;
			addr_ff <= nxt_addr;
		end
	end

	assign ready_o          = in_idle;
	assign done_o           = in_done;
	assign owned_o          = owned_ff;
	assign held_o           = held_ff;
	// Memory select never asserts: this controller only reaches the tokens
	assign mem_select_n_o   = 1'b1;                         // RQ6
	assign token_select_n_o = sel_n_ff;
	assign out_en_n_o       = oe_n_ff;
	assign write_n_o        = write_n_ff;
	assign addr_o           = addr_ff;
	assign data_o           = data_ff;
	assign data_oe_n_o      = drive_n_ff;
endmodule : token_host
`default_nettype wire

// ==== inc/token_host_pkg.sv ====
/*
 * Constants shared by the token host controller: pin timing counts,
 * token address layout and port widths.
 * Assumes a 100 MHz sys_clk_i and a device whose port pins are wired
 * straight to this controller.
 */
// Function
// RQ1: Device holds eight token latches apart from memory, reachable from both ports.
// RQ2: To claim, write zero to the latch, then read it back.
// RQ3: After a token write, keep select high for the release gap before reading.
// RQ4: Readback zero means owned; one means other side holds it, keep polling.
// RQ5: Write one to release a token or withdraw a pending request.
// RQ6: Token access drives token_select_n low with memory select held high.
// RQ7: Device decodes only address bits 0-2 for token accesses.
// RQ8: Output enable and write-not-read act as for ordinary memory cycles.
// RQ9: Device takes the written token value from data bit zero only.
// RQ10: Zero written to a free token reads zero here, one on the far port.
// RQ11: Only the owning port can change a held token.
// RQ12: Zero from the non-owner while held is recorded as pending.
// RQ13: Owner writing one frees it, or hands it to a pending requester.
// RQ14: A token read drives the value onto every data line.
// RQ15: Device latches the read value so a far write cannot disturb it.
// RQ16: Simultaneous claims within the contention window grant exactly one port.
// RQ17: A token read asserts token_select_n instead of memory select, plus output enable.
// RQ18: After start-up all eight tokens are free with no pending requests.
package token_host_pkg;
	localparam int TOKEN_COUNT      = 8;
	localparam int TOKEN_ADDR_W     = 3;
	localparam int DATA_W           = 16;
	localparam int ADDR_W           = 13;
	localparam int CLK_PERIOD_NS    = 10;
	// Minimum select high time between a token write and the following read
	localparam int TOKEN_RELEASE_GAP_NS = 10;
	localparam int RELEASE_GAP_CYC  =
		(TOKEN_RELEASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Strobe width of a write or read cycle on the pins
	localparam int STROBE_NS        = 30;
	localparam int STROBE_CYC       = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W            = 8;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_ONE  = 16'h0001;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b00_0001,
		ST_WRITE = 6'b00_0010,
		ST_GAP   = 6'b00_0100,
		ST_READ  = 6'b00_1000,
		ST_POLL  = 6'b01_0000,
		ST_DONE  = 6'b10_0000
	} host_state_t;
endpackage : token_host_pkg

// ==== hdl/cycle_timer.sv ====
/*
 * Down counter that times one pin phase.
 * Assumes the loader gives a nonzero count.
 */
`timescale 1ns/10ps
`default_nettype none
module cycle_timer #(
	parameter int W = 8
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] count_i,
	output logic              expired_o
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	assign nxt_cnt   = load_i ? count_i : (cnt_ff != '0 ? cnt_ff - W'(1) : cnt_ff);
	// Plain decode of the count: the loader reacts to this flag, so gating it
	// with load_i would close a combinational loop through the loader
	assign expired_o = (cnt_ff == W'(1));

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : cycle_timer
`default_nettype wire

// ==== tb/token_host_chk.sv ====
/* Pin checker for token_host; bound from the bench. */
`timescale 1ns/10ps
`default_nettype none
module token_host_chk(input wire logic sys_clk_i,rst_b_i,token_select_n_o,mem_select_n_o,
	write_n_o,data_oe_n_o,out_en_n_o);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!rst_b_i);
chk_mem_sel_idle: assert property (mem_select_n_o) else $error("mem sel");
chk_read_no_drive: assert property (!token_select_n_o&&write_n_o |-> data_oe_n_o) else $error("rd");
chk_write_drives: assert property (!token_select_n_o&&!write_n_o |-> !data_oe_n_o) else $error("wr");
chk_release_gap: assert property ($past(!token_select_n_o&&!write_n_o) |-> token_select_n_o||!write_n_o)
	else $error("gap");
chk_strobe_hold: assert property ($fell(token_select_n_o) |=> $stable(write_n_o)[*2]) else $error("strb");
chk_read_enables: assert property (!token_select_n_o&&write_n_o |-> !out_en_n_o) else $error("oe");
endmodule : token_host_chk
`default_nettype wire

// ==== tb/token_dev_model.sv ====
/* Token latch model: this port on pins, far port by wr(2,..) calls. */
`timescale 1ns/10ps
`default_nettype none
module token_dev_model(input wire logic clk,sel_n,we_n,oe_n,input wire logic [12:0] a,
	input wire logic [15:0] d,output logic [15:0] q);
logic [1:0] own[8]='{default:0},pend[8]='{default:0}; logic w,v; logic [2:0] i;
function automatic void wr(int p,int t,bit b);
	if(!b) begin if(own[t]==0) own[t]=2'(p); else if(own[t]!=p) pend[t][p-1]=1; end
	else if(own[t]==p) begin own[t]=pend[t][2-p]?2'(3-p):0; pend[t]=0; end else pend[t][p-1]=0;
endfunction
always @(posedge clk) if(!sel_n) {w,i,v}<={!we_n,a[2:0],we_n?own[a[2:0]]!=1:d[0]};
always @(posedge sel_n) if(w) wr(1,i,v);
// Released bus shows the inverse so a stale value never passes
assign q=!sel_n&&!oe_n&&we_n?{16{v}}:~{16{v}};
endmodule
`default_nettype wire

// ==== tb/token_host_bench.sv ====
/* Bench for token_host with the latch model on its pins. */
`timescale 1ns/10ps
`default_nettype none
module token_host_bench;
logic clk=0,rb=0,cl=0,rl=0,cn=0,rdy,dn,ow,sn,on,wn; logic [2:0] ix=0; logic [7:0] hd;
logic [12:0] a; logic [15:0] di,dq; int error_cnt=0,num_checks=0; logic [31:0] lf=32'h0176_f929;
initial forever #5 clk=~clk;
token_host i_dut(.sys_clk_i(clk),.rst_b_i(rb),.claim_i(cl),.release_i(rl),.cancel_i(cn),
	.token_idx_i(ix),.ready_o(rdy),.done_o(dn),.owned_o(ow),.held_o(hd),.token_select_n_o(sn),
	.mem_select_n_o(),.out_en_n_o(on),.write_n_o(wn),.addr_o(a),.data_i(dq),.data_o(di),
	.data_oe_n_o());
token_dev_model i_dev(.clk(clk),.sel_n(sn),.we_n(wn),.oe_n(on),.a(a),.d(di),.q(dq));
function logic [31:0] nx(logic [31:0] s); return {s[30:0],^(s&32'h8020_0003)}; endfunction : nx
task chk(logic [7:0] g,e); num_checks++; if(g!==e) begin error_cnt++;
	$display("[FAIL] %0t %h %h",$time,g,e); end endtask : chk
task stop_test; $display("checks %0d errors %0d",num_checks,error_cnt);
	if(error_cnt==0&&num_checks>0) $display("ALL CHECKS OK"); else $display("CHECKS NOT OK"); $finish; endtask : stop_test
task op(logic c,r,x,logic [2:0] t); int n;
	for(n=0;n<999&&rdy!==1;n++) @(negedge clk);
	@(posedge clk); {cl,rl,cn,ix}<={c,r,x,t}; @(posedge clk); {cl,rl,cn}<=0;
	for(;n<999&&dn!==1;n++) @(negedge clk);
	if(n>=999) begin error_cnt++; stop_test; end
endtask : op
initial begin
	repeat(16) @(posedge clk); rb<=1; @(negedge clk); chk(hd,0);
	repeat(4) begin lf=nx(lf);
		op(1,0,0,lf[2:0]); chk(ow,1);
		i_dev.wr(2,ix,0); op(0,1,0,ix); chk(i_dev.own[ix],2);
		fork op(1,0,0,ix); begin repeat(60) @(posedge clk); i_dev.wr(2,ix,1); end join
		chk(ow,1); op(0,1,0,ix); chk(hd,0);
		i_dev.wr(2,ix,0); fork op(1,0,0,ix); begin repeat(30) @(posedge clk); cn<=1; @(posedge clk); cn<=0; end join
		chk(i_dev.pend[ix],0); chk(ow,0); i_dev.wr(2,ix,1); $display("round done");
	end
	stop_test;
end
endmodule : token_host_bench
bind token_host token_host_chk i_chk(.sys_clk_i,.rst_b_i,.token_select_n_o,.mem_select_n_o,.write_n_o,
	.data_oe_n_o,.out_en_n_o);
`default_nettype wire
